//--- src/npc_axil_slave.sv
/*
  AXI4-Lite slave that turns bus transfers into register strobes.
  Assumes a single clock; one write and one read outstanding at most.
*/
`timescale 1ns/1ns
module npc_axil_slave
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // write channels
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  npc_reg_if.slave rb
);
  import npc_pkg::*;
  logic awHeld_r, wHeld_r, bvalid_r, rvalid_r;
  logic [9:0] awIdx_r;
  logic [15:0] wData_r;
  logic [1:0] wStrb_r, bresp_r, rresp_r;
  logic [15:0] rdata_r;
  wire doWrite = ce & awHeld_r & wHeld_r & ~bvalid_r;
  wire doRead = arvalid & arready;

  // ------------------------------
  // handshakes; a low clock enable stalls every channel
  // ------------------------------
  assign awready = ce & ~awHeld_r;
  assign wready = ce & ~wHeld_r;
  assign arready = ce & ~rvalid_r;
  assign bvalid = bvalid_r & ce;
  assign rvalid = rvalid_r & ce;
  assign bresp = bresp_r;
  assign rresp = rresp_r;
  assign rdata = {16'h0000, rdata_r};
  assign rb.wrEn = doWrite;
  assign rb.wIdx = awIdx_r;
  assign rb.wdata = wData_r;
  assign rb.wstrb = wStrb_r;
  assign rb.rdEn = doRead;
  assign rb.rIdx = araddr[11:2];

  // write path: address and data taken in either order
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      bvalid_r <= 1'b0;
      awIdx_r <= 10'h000;
      wData_r <= 16'h0000;
      wStrb_r <= 2'h0;
      bresp_r <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        awHeld_r <= 1'b1;
        awIdx_r <= awaddr[11:2];
      end
      if (wvalid && wready)
      begin
        wHeld_r <= 1'b1;
        wData_r <= wdata[15:0];
        wStrb_r <= wstrb[1:0];
      end
      if (doWrite)
      begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= rb.wHit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && bready)
        bvalid_r <= 1'b0;
    end

  // read path: data captured at the address handshake
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 16'h0000;
      rresp_r <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (doRead)
      begin
        rvalid_r <= 1'b1;
        rdata_r <= rb.rdata;
        rresp_r <= rb.rHit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_r && rready)
        rvalid_r <= 1'b0;
    end
endmodule // npc_axil_slave

//--- src/npc_mii_shape.sv
/*
  Receive-side MII presentation: carrier extension, preamble pass and
  serial 10M data. Assumes inputs come from logic on the same clock.
*/
`timescale 1ns/1ns
module npc_mii_shape
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // mode controls; carrier extension and serial already qualified by speed
  input wire logic crsExtend,
  input wire logic preambleOn,
  input wire logic serialOn,
  // raw receive signals
  input wire logic crsIn,
  input wire logic rxDvIn,
  input wire logic [3:0] rxdIn,
  input wire logic serialBitIn,
  // shaped receive signals
  output logic crsOut,
  output logic rxDvOut,
  output logic [3:0] rxdOut
);
  // preamble pass opens data valid with carrier, not with the delimiter
  wire dvNxt = preambleOn ? crsIn : rxDvIn;
  wire crsNxt = crsIn | (crsExtend & dvNxt);
  wire [3:0] rxdNxt = serialOn ? {3'h0, serialBitIn} : rxdIn;

  // outputs registered so the MAC sees one clean edge
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      crsOut <= 1'b0;
      rxDvOut <= 1'b0;
      rxdOut <= 4'h0;
    end
    else if (ce)
    begin
      crsOut <= crsNxt;
      rxDvOut <= dvNxt;
      rxdOut <= rxdNxt;
    end
endmodule // npc_mii_shape

//--- src/npc_pkg.sv
/*
  Shared constants for the next-page and port configuration register bank:
  word indices, field positions, reset values, write masks, bus responses.
  Assumes nothing of its surroundings; imported by npc_axil_slave, npc_port_regs and the verification modules.
*/
package npc_pkg;
  // ----------------------------------------
  // register word indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [9:0] NPT_IDX = 10'h007;
  localparam logic [9:0] LPN_IDX = 10'h008;
  localparam logic [9:0] CFG_IDX = 10'h010;
  localparam logic [9:0] STS_IDX = 10'h011;
  // ----------------------------------------
  // page word fields
  // ----------------------------------------
  localparam int MORE_PAGES_FLAG_BIT = 15;
  localparam int FORMATTED_PAGE_FLAG_BIT = 13;
  localparam int COMPLIANCE_CONFIRM_BIT = 12;
  localparam int TOGGLE_BIT = 11;
  localparam logic [15:0] TOGGLE_MASK = 16'h0800;
  // ----------------------------------------
  // port configuration fields
  // ----------------------------------------
  localparam int LINK_TEST_OFF_BIT = 14;
  localparam int TX_OFF_BIT = 13;
  localparam int SCR_BYP_BIT = 12;
  localparam int BLK_BYP_BIT = 11;
  localparam int JABBER_OFF_BIT = 10;
  localparam int HEARTBEAT_BIT = 9;
  localparam int LOOP_OFF_BIT = 8;
  localparam int CRS_EXT_BIT = 7;
  localparam int PREAMBLE_BIT = 5;
  localparam int SERIAL_BIT = 3;
  localparam int FEF_BIT = 2;
  localparam int ALT_PAGE_BIT = 1;
  localparam int MEDIA_BIT = 0;
  // status word fields
  localparam int PAGE_RX_BIT = 0;
  localparam int LINK_PASS_BIT = 1;
  // ----------------------------------------
  // reset values and writable bits
  // ----------------------------------------
  localparam logic [15:0] NPT_RST = 16'h2001;
  localparam logic [15:0] LPN_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'h0084;
  localparam logic [15:0] NPT_WMASK = 16'hBFFF;
  localparam logic [15:0] CFG_WMASK = 16'h7FAF;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // media strap capture sequence
  typedef enum logic [3:0] {STRAP_FILL1 = 4'h1, STRAP_FILL2 = 4'h2, STRAP_TAKE = 4'h4, STRAP_RUN = 4'h8} npc_strap_e;

  // true for a word index that holds a register
  function automatic logic npc_mapped(input logic [9:0] idx);
    return (idx == NPT_IDX) || (idx == LPN_IDX) || (idx == CFG_IDX) || (idx == STS_IDX);
  endfunction
endpackage

//--- src/npc_port_regs.sv
/*
  Per-port next-page and port configuration register bank with AXI4-Lite
  access, page exchange with the auto-negotiation engine and mode outputs.
  Assumes the engine, status inputs and MII receive signals share mclk;
  only the media select pin is asynchronous.
*/
// Overview of operation
// R1: more-pages bit drives transmitted page continuation
// R2: message-page bit selects page format, resets one
// R3: compliance bit sent in transmitted page
// R4: toggle is inverse of last sent toggle
// R5: eleven-bit code transmitted, resets to one
// R6: partner more-pages bit loaded from received page
// R7: partner acknowledge bit loaded from received page
// R8: partner message-page bit loaded from page
// R9: partner compliance bit loaded from page
// R10: partner toggle and code exposed, reset zero
// R11: link test disable forces link pass
// R12: transmit disable turns off twisted-pair transmitter
// R13: scrambler bypass in 100BASE-TX only
// R14: block code bypass in 100BASE-TX only
// R15: jabber disable, heartbeat enable in 10BASE-T
// R16: half-duplex 10BASE-T loopback unless disabled
// R17: carrier held until data valid drops; the code extends carrier only in 10BASE-T (bit 7 gated by tenMode)
// R18: preamble pass raises data valid with carrier
// R19: serial 10M data on bit zero
// R20: far-end fault sent only when enabled
// R21: alternate next-page handling enable bit
// R22: media select latched from pin at reset
// R23: alternate mode clears page-received on conditions
// R24: reserved bits read zero, writes ignored
`timescale 1ns/1ns
module npc_port_regs
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // AXI4-Lite write channels
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // auto-negotiation engine
  output logic [15:0] txPage,
  input wire logic txPageSent,
  input wire logic [15:0] rxPage,
  input wire logic rxPageValid,
  input wire logic pageRxVar,
  input wire logic anTxDisable,
  output logic pageReceived,
  // line status
  input wire logic speed100,
  input wire logic fullDuplex,
  input wire logic linkTestOk,
  input wire logic mediaSelectPin,
  // mode controls
  output logic linkPass,
  output logic tpTxEnable,
  output logic scrBypass,
  output logic blockCodeBypass,
  output logic jabberEnable,
  output logic sqeEnable,
  output logic tpLoopbackEnable,
  output logic fefEnable,
  output logic altNextPageEn,
  output logic fiberMode,
  // MII receive
  input wire logic crsIn,
  input wire logic rxDvIn,
  input wire logic [3:0] rxdIn,
  input wire logic serialBitIn,
  output logic crsOut,
  output logic rxDvOut,
  output logic [3:0] rxdOut
);
  import npc_pkg::*;

  // --------------------------------------------------
  // declarations
  // --------------------------------------------------
  npc_reg_if rb ();
  logic [15:0] npt_r, npt_nxt, lpn_r, lpn_nxt, cfg_r, cfg_nxt;
  logic pageRx_r, pageRx_nxt;
  logic pinMeta_r, pinSync_r;
  npc_strap_e strap_r, strap_nxt;
  logic [9:0] ctl_r, ctl_nxt;
  logic [15:0] nptWrVal, cfgWrVal;
  logic tenMode, altOn;

  // byte-lane merge of a write, keeping read-only and reserved bits
  function automatic logic [15:0] npc_merge(input logic [15:0] old, input logic [15:0] wd,
                                            input logic [1:0] strb, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    return (old & ~lanes) | (wd & lanes);
  endfunction

  // --------------------------------------------------
  // bus slave and receive presentation
  // --------------------------------------------------
  npc_axil_slave u_slave (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .rb(rb.slave)
  );

  npc_mii_shape u_mii (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .crsExtend(cfg_r[CRS_EXT_BIT] & tenMode), // R17
    .preambleOn(cfg_r[PREAMBLE_BIT]), // R18
    .serialOn(cfg_r[SERIAL_BIT] & tenMode), // R19
    .crsIn(crsIn),
    .rxDvIn(rxDvIn),
    .rxdIn(rxdIn),
    .serialBitIn(serialBitIn),
    .crsOut(crsOut),
    .rxDvOut(rxDvOut),
    .rxdOut(rxdOut)
  );

  // --------------------------------------------------
  // address decode
  // --------------------------------------------------
  wire nptWr = rb.wrEn && (rb.wIdx == NPT_IDX);
  wire cfgWr = rb.wrEn && (rb.wIdx == CFG_IDX);
  wire stsRd = rb.rdEn && (rb.rIdx == STS_IDX);
  wire [15:0] stsWord = {14'h0000, ctl_r[9], pageRx_r};
  assign rb.wHit = npc_mapped(rb.wIdx);
  assign rb.rHit = npc_mapped(rb.rIdx);
  // reserved bits never store a one, so plain registers read them as zero
  assign rb.rdata = (rb.rIdx == NPT_IDX) ? npt_r :
                    (rb.rIdx == LPN_IDX) ? lpn_r :
                    (rb.rIdx == CFG_IDX) ? cfg_r :
                    (rb.rIdx == STS_IDX) ? stsWord : 16'h0000; // R24

  // --------------------------------------------------
  // transmit page word
  // --------------------------------------------------
  // the engine flips toggle on each sent page; that wins over a write
  assign nptWrVal = nptWr ? npc_merge(npt_r, rb.wdata, rb.wstrb, NPT_WMASK) : npt_r; // R24
  assign npt_nxt = txPageSent ? ((nptWrVal & ~TOGGLE_MASK) | (~npt_r & TOGGLE_MASK)) : nptWrVal; // R4
  // page fields go to the engine straight from the register
  assign txPage = npt_r; // R1 R2 R3 R5

  // --------------------------------------------------
  // partner page and page-received flag
  // --------------------------------------------------
  assign altOn = cfg_r[ALT_PAGE_BIT]; // R21
  assign lpn_nxt = rxPageValid ? rxPage : lpn_r; // R6 R7 R8 R9 R10
  // a new page beats any clear that lands in the same cycle
  assign pageRx_nxt = rxPageValid | (pageRx_r & ~stsRd & ~(altOn & (~pageRxVar | anTxDisable))); // R23
  assign pageReceived = pageRx_r;

  // --------------------------------------------------
  // configuration word and media strap
  // --------------------------------------------------
  assign cfgWrVal = cfgWr ? npc_merge(cfg_r, rb.wdata, rb.wstrb, CFG_WMASK) : cfg_r; // R24
  assign cfg_nxt = (strap_r == STRAP_TAKE) ? {cfgWrVal[15:1], pinSync_r} : cfgWrVal; // R22

  // strap sequence waits for the synchroniser to fill before capture
  always_comb
  begin
    case (strap_r)
      STRAP_FILL1: strap_nxt = STRAP_FILL2;
      STRAP_FILL2: strap_nxt = STRAP_TAKE;
      STRAP_TAKE: strap_nxt = STRAP_RUN;
      STRAP_RUN: strap_nxt = STRAP_RUN;
      default: strap_nxt = STRAP_FILL1;
    endcase
  end

  // --------------------------------------------------
  // mode controls; bypass, 10BASE-T and loopback bits qualified by the present speed and duplex
  // --------------------------------------------------
  assign tenMode = ~speed100;
  assign ctl_nxt[0] = ~cfg_r[TX_OFF_BIT]; // R12
  assign ctl_nxt[1] = cfg_r[SCR_BYP_BIT] & speed100; // R13
  assign ctl_nxt[2] = cfg_r[BLK_BYP_BIT] & speed100; // R14
  assign ctl_nxt[3] = tenMode & ~cfg_r[JABBER_OFF_BIT]; // R15
  assign ctl_nxt[4] = tenMode & cfg_r[HEARTBEAT_BIT]; // R15
  assign ctl_nxt[5] = tenMode & ~fullDuplex & ~cfg_r[LOOP_OFF_BIT]; // R16
  assign ctl_nxt[6] = cfg_r[FEF_BIT]; // R20
  assign ctl_nxt[7] = altOn; // R21
  assign ctl_nxt[8] = cfg_r[MEDIA_BIT]; // R22
  assign ctl_nxt[9] = cfg_r[LINK_TEST_OFF_BIT] | linkTestOk; // R11
  assign tpTxEnable = ctl_r[0];
  assign scrBypass = ctl_r[1];
  assign blockCodeBypass = ctl_r[2];
  assign jabberEnable = ctl_r[3];
  assign sqeEnable = ctl_r[4];
  assign tpLoopbackEnable = ctl_r[5];
  assign fefEnable = ctl_r[6];
  assign altNextPageEn = ctl_r[7];
  assign fiberMode = ctl_r[8];
  assign linkPass = ctl_r[9];

  // --------------------------------------------------
  // state registers
  // --------------------------------------------------
  // pin synchroniser: second stage alone feeds the strap capture
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      pinMeta_r <= 1'b0;
      pinSync_r <= 1'b0;
    end
    else if (ce)
    begin
      pinMeta_r <= mediaSelectPin;
      pinSync_r <= pinMeta_r;
    end

  // register bank
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      npt_r <= NPT_RST;
      lpn_r <= LPN_RST;
      cfg_r <= CFG_RST;
      pageRx_r <= 1'b0;
      strap_r <= STRAP_FILL1;
      ctl_r <= 10'h000;
    end
    else if (ce)
    begin
      npt_r <= npt_nxt;
      lpn_r <= lpn_nxt;
      cfg_r <= cfg_nxt;
      pageRx_r <= pageRx_nxt;
      strap_r <= strap_nxt;
      ctl_r <= ctl_nxt;
    end

  // --------------------------------------------------
  // checks
  // --------------------------------------------------
  a_npt_reset: assert property ( // R2 R5
    @(posedge mclk) disable iff (!reset_n) $rose(reset_n) |-> txPage == NPT_RST)
    else $error("transmit page not at reset value");

  a_tx_fields: assert property ( // R1 R3 R5
    @(posedge mclk) disable iff (!reset_n)
    (ce && nptWr && rb.wstrb == 2'h3 && !txPageSent) |=> txPage == ($past(rb.wdata) & NPT_WMASK))
    else $error("transmit page does not follow the write");

  a_toggle_flip: assert property ( // R4
    @(posedge mclk) disable iff (!reset_n)
    (ce && txPageSent) |=> txPage[TOGGLE_BIT] != $past(txPage[TOGGLE_BIT]))
    else $error("toggle did not invert after a sent page");

  a_rx_load: assert property ( // R6 R7 R8 R9 R10
    @(posedge mclk) disable iff (!reset_n)
    (ce && rxPageValid) |=> lpn_r == $past(rxPage) && pageReceived)
    else $error("partner page not captured");

  a_link_force: assert property ( // R11
    @(posedge mclk) disable iff (!reset_n)
    (ce && cfg_r[LINK_TEST_OFF_BIT]) |=> linkPass)
    else $error("link pass not forced");

  a_tx_disable: assert property ( // R12
    @(posedge mclk) disable iff (!reset_n)
    (ce && cfg_r[TX_OFF_BIT]) |=> !tpTxEnable)
    else $error("transmitter left enabled");

  a_bypass_speed: assert property ( // R13 R14
    @(posedge mclk) disable iff (!reset_n)
    (ce && !speed100) |=> !scrBypass && !blockCodeBypass)
    else $error("bypass active outside 100 Mbps");

  a_page_clear: assert property ( // R23
    @(posedge mclk) disable iff (!reset_n)
    (ce && altOn && anTxDisable && !rxPageValid) |=> !pageReceived)
    else $error("page received flag not cleared");

  a_strap_take: assert property ( // R22
    @(posedge mclk) disable iff (!reset_n)
    (ce && strap_r == STRAP_TAKE) |=> cfg_r[MEDIA_BIT] == $past(pinSync_r) ##1 fiberMode == $past(cfg_r[MEDIA_BIT]))
    else $error("media select not latched from pin");

  a_reserved_zero: assert property ( // R24
    @(posedge mclk) disable iff (!reset_n)
    (rb.rdEn && rb.rIdx == CFG_IDX) |-> (rb.rdata & ~CFG_WMASK) == 16'h0000)
    else $error("reserved bits read nonzero");
endmodule // npc_port_regs

//--- src/npc_reg_if.sv
/*
  Simple register access carrier between the bus slave and the register bank.
  Assumes both ends run on the same clock; strobes are one-cycle pulses.
*/
`timescale 1ns/1ns
interface npc_reg_if;
  logic wrEn;
  logic [9:0] wIdx;
  logic [15:0] wdata;
  logic [1:0] wstrb;
  logic wHit;
  logic rdEn;
  logic [9:0] rIdx;
  logic [15:0] rdata;
  logic rHit;
  modport slave (output wrEn, wIdx, wdata, wstrb, rdEn, rIdx, input wHit, rdata, rHit);
  modport bank (input wrEn, wIdx, wdata, wstrb, rdEn, rIdx, output wHit, rdata, rHit);
endinterface

//--- verification/npc_an_partner.sv
/*
  Far-side model of the page exchange: sends partner pages, reports sent pages.
  Assumes one clock shared with the register bank; driven by testbench tasks.
*/
`timescale 1ns/1ns
module npc_an_partner
(
  // clock
  input wire logic mclk,
  // page link
  output logic txPageSent,
  output logic [15:0] rxPage,
  output logic rxPageValid,
  output logic pageRxVar,
  output logic anTxDisable
);
  import npc_pkg::*;
  logic partTog_r;
  // idle link at time zero, page-received variable true
  initial
  begin
    txPageSent = 1'b0;
    rxPage = 16'h0000;
    rxPageValid = 1'b0;
    pageRxVar = 1'b1;
    anTxDisable = 1'b0;
    partTog_r = 1'b0;
  end
  // one page word; stale data is inverted so nothing reads as still valid
  task send_page(input logic [15:0] w);
    @(posedge mclk);
    rxPage <= {w[15:12], partTog_r, w[10:0]};
    rxPageValid <= 1'b1;
    partTog_r <= ~partTog_r;
    @(posedge mclk);
    rxPageValid <= 1'b0;
    rxPage <= ~rxPage;
  endtask
  // engine reports the local page as sent
  task tx_sent;
    @(posedge mclk);
    txPageSent <= 1'b1;
    @(posedge mclk);
    txPageSent <= 1'b0;
  endtask
  // page-received variable and transmit disable levels
  task set_vars(input logic v, input logic d);
    @(posedge mclk);
    pageRxVar <= v;
    anTxDisable <= d;
  endtask
endmodule // npc_an_partner

//--- verification/testbench.sv
/*
  Self-checking bench for the port register bank over AXI4-Lite.
  Assumes the far-side model npc_an_partner and one 10 MHz clock.
*/
`timescale 1ns/1ns
module testbench;
  import npc_pkg::*;
  logic mclk = 1'b0, reset_n = 1'b0, ce = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000, rdata, rd, rv;
  logic [3:0] wstrb = 4'hF, rxdIn = 4'h0, rxdOut;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, txPageSent, rxPageValid, pageRxVar, anTxDisable;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] txPage, rxPage, cfg, npt, w;
  logic speed100 = 1'b0, fullDuplex = 1'b0, linkTestOk = 1'b0, mediaSelectPin = 1'b1;
  logic crsIn = 1'b0, rxDvIn = 1'b0, serialBitIn = 1'b0, ptog = 1'b0, aw, wd;
  logic pageReceived, linkPass, tpTxEnable, scrBypass, blockCodeBypass, jabberEnable, sqeEnable;
  logic tpLoopbackEnable, fefEnable, altNextPageEn, fiberMode, crsOut, rxDvOut;
  int fails = 0, checked = 0, cycles = 0, seed = 55130;
  wire logic [9:0] modeVec = {linkPass, tpTxEnable, scrBypass, blockCodeBypass, jabberEnable, sqeEnable,
    tpLoopbackEnable, fefEnable, altNextPageEn, fiberMode};

  always #50 mclk = ~mclk;

  npc_port_regs dut_u (.mclk, .reset_n, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .txPage,
    .txPageSent, .rxPage, .rxPageValid, .pageRxVar, .anTxDisable, .pageReceived, .speed100, .fullDuplex,
    .linkTestOk, .mediaSelectPin, .linkPass, .tpTxEnable, .scrBypass, .blockCodeBypass, .jabberEnable,
    .sqeEnable, .tpLoopbackEnable, .fefEnable, .altNextPageEn, .fiberMode, .crsIn, .rxDvIn, .rxdIn,
    .serialBitIn, .crsOut, .rxDvOut, .rxdOut);
  npc_an_partner pm_u (.mclk, .txPageSent, .rxPage, .rxPageValid, .pageRxVar, .anTxDisable);

  // mode outputs implied by a config word and the line status
  function automatic logic [9:0] modes(input logic [15:0] c, input logic s, input logic fd, input logic lt);
    return {c[14] | lt, ~c[13], s & c[12], s & c[11], ~s & ~c[10], ~s & c[9], ~s & ~fd & ~c[8], c[2], c[1], c[0]};
  endfunction

  task chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask

  // address and data offered together, each released when taken
  task axi_wr(input logic [11:0] a, input logic [15:0] d, output logic [1:0] r);
    @(posedge mclk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1'b0;
    wd = 1'b0;
    while (!(aw && wd))
    begin
      @(posedge mclk);
      aw = aw | (awready === 1'b1);
      wd = wd | (wready === 1'b1);
      awvalid <= ~aw;
      wvalid <= ~wd;
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task rdc(input logic [11:0] a, input logic [15:0] e, input logic [1:0] er, input string m);
    axi_rd(a, rd, rs);
    chk(rd === {16'h0000, e} && rs === er, m);
  endtask

  task finish_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // hang guard: the whole run needs well under this many cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      $display("mismatch %0t timeout", $time);
      finish_test();
    end
  end

  // main sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk(modeVec === modes(CFG_RST | 16'h0001, 1'b0, 1'b0, 1'b0), "reset modes");
    rdc(12'h01C, NPT_RST, RESP_OKAY, "npt reset");
    rdc(12'h020, LPN_RST, RESP_OKAY, "partner reset");
    rdc(12'h040, CFG_RST | 16'h0001, RESP_OKAY, "cfg reset");
    rdc(12'h030, 16'h0000, RESP_SLVERR, "unmapped read");
    axi_wr(12'h030, 16'hFFFF, rs);
    chk(rs === RESP_SLVERR, "unmapped write");
    axi_wr(12'h020, 16'hFFFF, rs);
    chk(rs === RESP_OKAY, "partner write response");
    rdc(12'h020, LPN_RST, RESP_OKAY, "partner read only");
    // transmit page: corner words first, then random ones
    for (int i = 0; i < 6; i++)
    begin
      rv = $random(seed);
      w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : rv[15:0];
      axi_wr(12'h01C, w, rs);
      npt = w & NPT_WMASK;
      rdc(12'h01C, npt, RESP_OKAY, "npt readback");
      chk(txPage === npt, "tx page");
      pm_u.tx_sent();
      #1;
      chk(txPage === (npt ^ TOGGLE_MASK), "toggle");
    end
    // partner pages, back to back with readback
    repeat (4)
    begin
      rv = $random(seed);
      pm_u.send_page(rv[15:0]);
      #1;
      chk(pageReceived === 1'b1, "page flag");
      rdc(12'h020, {rv[15:12], ptog, rv[10:0]}, RESP_OKAY, "partner page");
      ptog = ~ptog;
    end
    // status read returns the flag and clears it; then one more page sets it again
    rdc(12'h044, 16'h0001, RESP_OKAY, "status read");
    chk(pageReceived === 1'b0, "status clear");
    rv = $random(seed);
    pm_u.send_page(rv[15:0]);
    ptog = ~ptog;
    // flag survives a false page variable until alternate handling is on
    pm_u.set_vars(1'b0, 1'b0);
    repeat (3) @(posedge mclk);
    #1;
    chk(pageReceived === 1'b1, "flag held");
    axi_wr(12'h040, 16'h0086, rs);
    repeat (3) @(posedge mclk);
    #1;
    chk(pageReceived === 1'b0 && altNextPageEn === 1'b1, "alt clear var");
    pm_u.set_vars(1'b1, 1'b1);
    pm_u.send_page(16'h1234);
    ptog = ~ptog;
    repeat (3) @(posedge mclk);
    #1;
    chk(pageReceived === 1'b0, "alt clear tx off");
    pm_u.set_vars(1'b1, 1'b0);
    // config words against line status and receive shaping
    for (int i = 0; i < 40; i++)
    begin
      rv = $random(seed);
      cfg = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : rv[15:0];
      axi_wr(12'h040, cfg, rs);
      cfg = cfg & CFG_WMASK;
      rdc(12'h040, cfg, RESP_OKAY, "cfg readback");
      @(posedge mclk);
      rv = $random(seed);
      {speed100, fullDuplex, linkTestOk} <= rv[2:0];
      {crsIn, rxDvIn, serialBitIn, rxdIn} <= rv[10:4];
      repeat (2) @(posedge mclk);
      #1;
      chk(modeVec === modes(cfg, speed100, fullDuplex, linkTestOk), "modes");
      chk(rxDvOut === (cfg[5] ? crsIn : rxDvIn), "data valid");
      chk(rxdOut === ((cfg[3] & ~speed100) ? {3'h0, serialBitIn} : rxdIn), "receive data");
      chk(crsOut === (crsIn | (cfg[7] & ~speed100 & (cfg[5] ? crsIn : rxDvIn))), "carrier");
    end
    // clock enable low freezes the mode outputs against a status change
    @(posedge mclk);
    w = {6'h00, modeVec};
    ce <= 1'b0;
    speed100 <= ~speed100;
    linkTestOk <= ~linkTestOk;
    repeat (3) @(posedge mclk);
    #1;
    chk(modeVec === w[9:0], "frozen modes");
    @(posedge mclk);
    ce <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(modeVec === modes(cfg, speed100, fullDuplex, linkTestOk), "modes after enable");
    finish_test();
  end
endmodule // testbench
